// ### bench/ifsp_far_end.sv
// Far-end model: clocks the link and moves whole frames
`timescale 1ns/1ps
`default_nettype none
module ifsp_far_end (
  // Link pins
  output var  logic link_serial_clock,
  output var  logic inbound_serial_line,
  input  wire logic outbound_serial_line,
  input  wire logic inbound_ready_line
);
  // Clock stands low between frames; line rests high
  initial begin
    link_serial_clock   = 1'h0;
    inbound_serial_line = 1'h1;
  end

  // One 6 ns period; data changes only while clock is low
  task automatic tick();
    #3 link_serial_clock = 1'h1;
    #3 link_serial_clock = 1'h0;
  endtask

  // Poll ready with clock pulses, bounded
  task automatic wait_ready(output logic ok);
    ok = 1'h0;
    for (int i = 0; i < 40 && !ok; i++) begin
      tick();
      ok = (inbound_ready_line === 1'h1);
    end
  endtask

  // Inbound frame; rd: ready after start, after tail
  task automatic send(input logic [7:0] b, input logic dst,
                      output logic [1:0] rd, output logic busy);
    logic [9:0] f;
    f    = {dst, b, 1'h0};
    busy = 1'h0;
    for (int k = 0; k < 10; k++) begin
      inbound_serial_line = f[k];
      tick();
      if (k == 0) rd[0] = inbound_ready_line;
      busy |= (outbound_serial_line !== 1'h1);
    end
    rd[1] = inbound_ready_line;
    inbound_serial_line = 1'h1;
  endtask

  // Outbound frame; stalls the clock after the start bit
  task automatic recv(input int stall, output logic [10:0] f,
                      output logic ok);
    ok = 1'h0;
    for (int i = 0; i < 40 && !ok; i++) begin
      tick();
      ok = (outbound_serial_line === 1'h0);
    end
    #(stall);
    f[0] = outbound_serial_line;
    for (int k = 1; k < 11; k++) begin
      tick();
      f[k] = outbound_serial_line;
    end
  endtask
endmodule // ifsp_far_end
`default_nettype wire

// ### bench/isolated_fast_serial_port_test.sv
// Self-checking bench for the isolated fast serial port
`timescale 1ns/1ps
`default_nettype none
module isolated_fast_serial_port_test;
  import ifsp_pkg::*;
  logic          clk;
  logic          rst_b;
  logic          cfg_fast_mode;
  logic          tx_in_ready;
  logic          rx_out_ready;
  ifsp_cmd_type  mode_cmd;
  ifsp_byte_type tx_in;
  ifsp_byte_type rx_out;
  wire logic     link_serial_clock;
  wire logic     inbound_serial_line;
  wire logic     outbound_serial_line;
  wire logic     inbound_ready_line;
  int            fails = 0;
  int            n_checks = 0;
  logic [31:0]   seed = 32'h59C6;

  // Device and far end
  ifsp_top DUT (.clk, .rst_b, .cfg_fast_mode, .mode_cmd, .tx_in,
    .tx_in_ready, .rx_out, .rx_out_ready, .link_serial_clock,
    .outbound_serial_line, .inbound_serial_line, .inbound_ready_line);
  ifsp_far_end far (.link_serial_clock, .inbound_serial_line,
    .outbound_serial_line, .inbound_ready_line);

  // 125 MHz system clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Repeatable pseudo-random source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Expected line after edges 0..10 of an outbound frame
  function automatic logic [10:0] exp_frame(input logic [7:0] b);
    return {LINE_IDLE, SRC_BIT, b, START_BIT};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A bounded wait that ran out ends the run
  task automatic must(input string nm, input logic ok);
    chk(nm, 16'h1, {15'h0, ok});
    if (ok !== 1'h1) report_and_stop();
  endtask

  // Inputs move 1 ns after the rising edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic host_send(input logic [7:0] b);
    logic r;
    logic ok;
    ok = 1'h0;
    step();
    tx_in = '{valid: 1'h1, data: b};
    for (int i = 0; i < 60 && !ok; i++) begin
      r = tx_in_ready;
      step();
      ok = (r === 1'h1);
    end
    tx_in.valid = 1'h0;
    must("tx_taken", ok);
  endtask

  task automatic host_take(input logic [7:0] b);
    logic ok;
    ok = 1'h0;
    step();
    for (int i = 0; i < 20 && !ok; i++) begin
      ok = (rx_out.valid === 1'h1);
      if (!ok) step();
    end
    must("rx_valid", ok);
    chk("rx_data", {8'h0, b}, {8'h0, rx_out.data});
    rx_out_ready = 1'h1;
    step();
    rx_out_ready = 1'h0;
  endtask

  task automatic cmd(input logic [7:0] v);
    step();
    mode_cmd = '{valid: 1'h1, value: v};
    step();
    mode_cmd.valid = 1'h0;
  endtask

  // Main sequence
  initial begin
    logic [10:0] f;
    logic [1:0]  rd;
    logic [7:0]  b;
    logic        ok;
    logic        bz;
    rst_b = 1'h1;
    cfg_fast_mode = 1'h0;
    mode_cmd = '0;
    tx_in = '0;
    rx_out_ready = 1'h0;
    // Fall after time zero so link flops, with no clock yet, see it
    #1 rst_b = 1'h0;
    repeat (8) @(posedge clk);
    chk("rst_out", 16'h1, {15'h0, outbound_serial_line});
    #1 rst_b = 1'h1;
    // Mode not selected: link stays inactive
    repeat (4) step();
    chk("off_tx_rdy", 16'h0, {15'h0, tx_in_ready});
    repeat (6) far.tick();
    chk("off_rdy", 16'h0, {15'h0, inbound_ready_line});
    step();
    cfg_fast_mode = 1'h1;
    far.wait_ready(ok);
    must("ready_up", ok);
    // Random traffic both ways, first byte a corner value
    for (int n = 0; n < 4; n++) begin
      seed = xs(seed);
      b = (n == 0) ? 8'h80 : seed[7:0];
      host_send(b);
      far.recv(int'(seed[11:8]) * 8, f, ok);
      must("start_seen", ok);
      chk("out_frame", exp_frame(b), f);
      far.wait_ready(ok);
      must("ready_back", ok);
      seed = xs(seed);
      far.send(seed[7:0], DESTINATION_SELECT_BIT_BIT, rd, bz);
      chk("ready_drop", 16'h0, rd);
      if (n == 1) begin
        repeat (10) far.tick();
        chk("ready_held", 16'h0, inbound_ready_line);
      end
      host_take(seed[7:0]);
    end
    // Destination bit set: byte never reaches the host
    far.wait_ready(ok);
    must("ready_destination_select_bit", ok);
    far.send(8'hA5, 1'h1, rd, bz);
    repeat (6) step();
    chk("destination_select_bit_drop", 16'h0, {15'h0, rx_out.valid});
    // Byte pending while a frame comes in
    far.wait_ready(ok);
    must("ready_up2", ok);
    host_send(8'h3C);
    far.send(8'h5A, DESTINATION_SELECT_BIT_BIT, rd, bz);
    chk("half_duplex", 16'h0, {15'h0, bz});
    far.recv(0, f, ok);
    must("late_start", ok);
    chk("late_frame", exp_frame(8'h3C), f);
    host_take(8'h5A);
    // Hold, stray value ignored, byte kept then sent
    cmd(MODE_HOLD);
    cmd(8'h55);
    repeat (4) far.tick();
    host_send(8'hC3);
    ok = 1'h1;
    repeat (20) begin
      far.tick();
      ok &= (outbound_serial_line === LINE_IDLE);
    end
    chk("held_idle", 16'h1, {15'h0, ok});
    cmd(MODE_RUN);
    far.recv(16, f, ok);
    must("resume", ok);
    chk("resume_frame", exp_frame(8'hC3), f);
    report_and_stop();
  end
endmodule // isolated_fast_serial_port_test
`default_nettype wire

// ### hw/ifsp_pkg.sv
// Package: constants and types of the isolated fast serial port
// Behaviour
// - Four wires: clock, out, in, ready.
// - Link runs only when fast mode configured.
// - Command 0x10 holds link; bytes still buffered.
// - Command 0x00 releases; buffered bytes then sent.
// - Pending byte starts frame: out line low.
// - No outbound start during inbound frame.
// - Outbound frame starts with zero bit.
// - Outbound data bits go LSB first.
// - Outbound frame ends with zero source bit.
// - Inbound frame starts with zero bit.
// - Inbound start drops ready next rising edge.
// - Inbound bits 0..7 assembled LSB first.
// - Inbound byte kept only when destination bit is zero.
// - Ready stays low until buffer space returns.
package ifsp_pkg;

  // Host mode command values
  localparam logic [7:0] MODE_HOLD = 8'h10;
  localparam logic [7:0] MODE_RUN  = 8'h00;

  // Frame layout: bits after the start bit
  localparam logic [3:0] FRAME_TAIL = 4'h9;
  localparam logic [3:0] LAST_SLOT  = 4'h1;
  localparam logic [3:0] CNT_DONE   = 4'h0;
  localparam logic       START_BIT  = 1'h0;
  localparam logic       SRC_BIT    = 1'h0;
  localparam logic       DESTINATION_SELECT_BIT_BIT   = 1'h0;
  localparam logic       LINE_IDLE  = 1'h1;

  // Values after reset
  localparam logic       HOLD_RST   = 1'h0;
  localparam logic       READY_RST  = 1'h0;
  localparam logic [7:0] BYTE_RST   = 8'h00;

  // Holding register state on the system clock
  typedef enum logic [1:0] {
    TH_EMPTY = 2'b00,
    TH_FULL  = 2'b01,
    TH_SENT  = 2'b10
  } ifsp_hold_type;

  // Shifter state on the link clock
  typedef enum logic {
    LK_IDLE = 1'b0,
    LK_BUSY = 1'b1
  } ifsp_link_type;

  // Byte with its valid flag
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ifsp_byte_type;

  // Host mode command strobe
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } ifsp_cmd_type;

endpackage

// ### hw/ifsp_sync.sv
// Two-flop synchroniser for independent level bits
`timescale 1ns/1ps
`default_nettype none
module ifsp_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Bits in and out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First flop feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // ifsp_sync
`default_nettype wire

// ### hw/ifsp_top.sv
// Isolated fast serial port: host side and link side
`timescale 1ns/1ps
`default_nettype none
module ifsp_top
  import ifsp_pkg::*;
(
  // System clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Mode selection
  input  wire logic          cfg_fast_mode,
  input  wire ifsp_cmd_type  mode_cmd,
  // Bytes from the host
  input  wire ifsp_byte_type tx_in,
  output var  logic          tx_in_ready,
  // Bytes to the host
  output var  ifsp_byte_type rx_out,
  input  wire logic          rx_out_ready,
  // Link pins
  input  wire logic          link_serial_clock,
  output var  logic          outbound_serial_line,
  input  wire logic          inbound_serial_line,
  output var  logic          inbound_ready_line
);

  // System clock side
  logic          hold_r;
  logic          run_r;
  ifsp_hold_type th_r;
  ifsp_hold_type th_nxt;
  logic [7:0]    tx_data_r;
  logic          tx_req_r;
  logic          tx_ready_r;
  ifsp_byte_type rx_out_r;
  logic          rx_seen_r;
  logic          rx_ack_r;
  logic          tx_take;
  logic          tack_s;
  logic          rtgl_s;

  // Link clock side
  ifsp_link_type tx_st_r;
  ifsp_link_type rx_st_r;
  logic [3:0]    tx_cnt_r;
  logic [3:0]    rx_cnt_r;
  logic [8:0]    tx_sh_r;
  logic [7:0]    rx_sh_r;
  logic [7:0]    rx_byte_r;
  logic          tx_ack_r;
  logic          rx_tgl_r;
  logic          out_r;
  logic          cts_r;
  logic          run_s;
  logic          req_s;
  logic          rack_s;
  logic          start_seen;
  logic          tx_go;

  // Crossings, one per direction
  ifsp_sync #(.W(3)) u_to_link (
    .clk   (link_serial_clock),
    .rst_b (rst_b),
    .d     ({run_r, tx_req_r, rx_ack_r}),
    .q     ({run_s, req_s, rack_s})
  );

  ifsp_sync #(.W(2)) u_to_sys (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({tx_ack_r, rx_tgl_r}),
    .q     ({tack_s, rtgl_s})
  );

  // Mode command: hold and release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= HOLD_RST;
    end else if (mode_cmd.valid && mode_cmd.value == MODE_HOLD) begin
      hold_r <= 1'b1;
    end else if (mode_cmd.valid && mode_cmd.value == MODE_RUN) begin
      hold_r <= 1'b0;
    end
  end

  // Link may run only in fast mode and out of hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= HOLD_RST;
    end else begin
      run_r <= cfg_fast_mode && !hold_r;
    end
  end

  assign tx_take = tx_in.valid && tx_ready_r;

  // Holding register sequencing
  always_comb begin
    th_nxt = th_r;
    case (th_r)
      TH_EMPTY: if (tx_take) th_nxt = TH_FULL;
      TH_FULL:  if (run_r) th_nxt = TH_SENT;
      TH_SENT:  if (tack_s == tx_req_r) th_nxt = TH_EMPTY;
      default:  th_nxt = TH_EMPTY;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      th_r <= TH_EMPTY;
    end else begin
      th_r <= th_nxt;
    end
  end

  // Byte capture; accepted even while held
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_data_r <= BYTE_RST;
    end else if (tx_take) begin
      tx_data_r <= tx_in.data;
    end
  end

  // Ready registered so the port comes from a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_ready_r <= READY_RST;
    end else begin
      tx_ready_r <= (th_nxt == TH_EMPTY) && cfg_fast_mode;
    end
  end

  // Request toggle; data stays frozen until acknowledged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_req_r <= 1'b0;
    end else if (th_r == TH_FULL && run_r) begin
      tx_req_r <= !tx_req_r;
    end
  end

  // Inbound byte to host; ack only once host has it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_out_r  <= '0;
      rx_seen_r <= 1'b0;
      rx_ack_r  <= 1'b0;
    end else if (rtgl_s != rx_seen_r) begin
      rx_out_r  <= '{valid: 1'b1, data: rx_byte_r};
      rx_seen_r <= rtgl_s;
    end else if (rx_out_r.valid && rx_out_ready) begin
      rx_out_r.valid <= 1'b0;
      rx_ack_r       <= rx_seen_r;
    end
  end

  // Inbound start only counts while ready was offered
  assign start_seen = rx_st_r == LK_IDLE && cts_r &&
                      inbound_serial_line == START_BIT;
  // Outbound start only with the link quiet
  assign tx_go = run_s && tx_st_r == LK_IDLE && rx_st_r == LK_IDLE &&
                 !start_seen && inbound_serial_line &&
                 req_s != tx_ack_r;

  // Outbound shifter; clock comes only from outside
  always_ff @(posedge link_serial_clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_r  <= LK_IDLE;
      tx_cnt_r <= CNT_DONE;
      tx_sh_r  <= '1;
      out_r    <= LINE_IDLE;
      tx_ack_r <= 1'b0;
    end else if (!run_s) begin
      tx_st_r <= LK_IDLE; // Aborted frame is resent on release
      out_r   <= LINE_IDLE;
    end else begin
      case (tx_st_r)
        LK_IDLE: begin
          if (tx_go) begin
            out_r    <= START_BIT;
            tx_sh_r  <= {SRC_BIT, tx_data_r};
            tx_cnt_r <= FRAME_TAIL;
            tx_st_r  <= LK_BUSY;
          end else begin
            out_r <= LINE_IDLE;
          end
        end
        LK_BUSY: begin
          if (tx_cnt_r != CNT_DONE) begin
            out_r    <= tx_sh_r[0];
            tx_sh_r  <= {LINE_IDLE, tx_sh_r[8:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
            // Ack on the last bit: the clock may stop after it
            if (tx_cnt_r == LAST_SLOT) tx_ack_r <= !tx_ack_r;
          end else begin
            out_r   <= LINE_IDLE;
            tx_st_r <= LK_IDLE;
          end
        end
        default: tx_st_r <= LK_IDLE;
      endcase
    end
  end

  // Inbound shifter
  always_ff @(posedge link_serial_clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_r   <= LK_IDLE;
      rx_cnt_r  <= CNT_DONE;
      rx_sh_r   <= BYTE_RST;
      rx_byte_r <= BYTE_RST;
      rx_tgl_r  <= 1'b0;
    end else if (!run_s) begin
      rx_st_r <= LK_IDLE;
    end else begin
      case (rx_st_r)
        LK_IDLE: begin
          if (start_seen) begin
            rx_st_r  <= LK_BUSY;
            rx_cnt_r <= FRAME_TAIL;
          end
        end
        LK_BUSY: begin
          rx_cnt_r <= rx_cnt_r - 4'h1;
          if (rx_cnt_r == LAST_SLOT) begin
            rx_st_r <= LK_IDLE;
            // Only destination zero exists here
            if (inbound_serial_line == DESTINATION_SELECT_BIT_BIT) begin
              rx_byte_r <= rx_sh_r;
              rx_tgl_r  <= !rx_tgl_r;
            end
          end else begin
            rx_sh_r <= {inbound_serial_line, rx_sh_r[7:1]};
          end
        end
        default: rx_st_r <= LK_IDLE;
      endcase
    end
  end

  // Ready: low from start bit until host has taken byte
  always_ff @(posedge link_serial_clock or negedge rst_b) begin
    if (!rst_b) begin
      cts_r <= READY_RST;
    end else begin
      cts_r <= run_s && !start_seen && rx_st_r == LK_IDLE &&
               tx_st_r == LK_IDLE && !tx_go &&
               rack_s == rx_tgl_r;
    end
  end

  // Four outputs, all driven from flops
  assign outbound_serial_line = out_r;
  assign inbound_ready_line   = cts_r;
  assign tx_in_ready          = tx_ready_r;
  assign rx_out               = rx_out_r;

  // Checks on the link clock
  property p_idle_high;
    @(posedge link_serial_clock) disable iff (!rst_b)
    !run_s |=> outbound_serial_line;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("outbound line not high while link stopped");

  property p_start_low;
    @(posedge link_serial_clock) disable iff (!rst_b)
    tx_go |=> !outbound_serial_line && tx_st_r == LK_BUSY;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("frame did not open with a low start bit");

  // Watch the pin itself, not the gating term that blocks the start
  property p_no_tx_in_rx;
    @(posedge link_serial_clock) disable iff (!rst_b)
    (rx_st_r == LK_BUSY || start_seen) |=> outbound_serial_line;
  endproperty
  a_no_tx_in_rx: assert property (p_no_tx_in_rx)
    else $error("outbound start during inbound frame");

  property p_lsb_first;
    @(posedge link_serial_clock) disable iff (!rst_b)
    (tx_go ##1 run_s) |=> outbound_serial_line == $past(tx_data_r[0], 2);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("first data bit is not the LSB");

  property p_src_zero;
    @(posedge link_serial_clock) disable iff (!rst_b)
    (run_s && tx_st_r == LK_BUSY && tx_cnt_r == LAST_SLOT)
      |=> outbound_serial_line == SRC_BIT;
  endproperty
  a_src_zero: assert property (p_src_zero)
    else $error("source bit not zero");

  // Only frames that ran to the end; a hold may cut one short
  property p_frame_len;
    @(posedge link_serial_clock) disable iff (!rst_b)
    (tx_go ##1 run_s [*8] ##1 run_s) |-> tx_st_r == LK_BUSY
      ##1 tx_st_r == LK_BUSY ##1 tx_st_r == LK_IDLE;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("outbound frame not ten bits long");

  property p_cts_drop;
    @(posedge link_serial_clock) disable iff (!rst_b)
    start_seen |=> !inbound_ready_line;
  endproperty
  a_cts_drop: assert property (p_cts_drop)
    else $error("ready not dropped after inbound start");

  property p_cts_wait;
    @(posedge link_serial_clock) disable iff (!rst_b)
    (run_s && rx_st_r == LK_BUSY && rx_cnt_r == LAST_SLOT &&
     inbound_serial_line == DESTINATION_SELECT_BIT_BIT) |=> !inbound_ready_line [*2];
  endproperty
  a_cts_wait: assert property (p_cts_wait)
    else $error("ready rose before byte was taken");

  // Checks on the system clock
  // Three held cycles: run_r lags hold_r by one flop
  property p_hold;
    @(posedge clk) disable iff (!rst_b)
    (hold_r && $past(hold_r) && $past(hold_r, 2)) |->
      (!run_r && (th_r != TH_SENT || $past(th_r) == TH_SENT));
  endproperty
  a_hold: assert property (p_hold)
    else $error("link running while held");

  property p_release;
    @(posedge clk) disable iff (!rst_b)
    (mode_cmd.valid && mode_cmd.value == MODE_RUN ##1 cfg_fast_mode)
      |=> run_r;
  endproperty
  a_release: assert property (p_release)
    else $error("link not released by run command");

endmodule // ifsp_top
`default_nettype wire
